// *** test/pmt_prog_model.sv ***
// Behavioural in-circuit programmer driving the shared serial data pin
`timescale 1ns/1ps
`default_nettype none
module pmt_prog_model (
   output logic ck,
   output logic en,
   output logic pad,
   input wire logic dev_o,
   input wire logic dev_oe
);
   logic d = 1'b0;
   // Once released, d toggles each clock so a stale bit never reads as valid
   assign pad = dev_oe ? dev_o : d;
   initial begin
      ck = 1'b0;
      en = 1'b0;
   end
   task automatic tick(input logic b, output logic s);
      d = b;
      #12 ck = 1'b1;
      #24 ck = 1'b0;
      s = pad;
      #12;
   endtask
   task automatic mode(input logic on);
      logic s;
      en = on;
      repeat (4) tick(~d, s);
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] v);
      logic [28:0] f;
      logic s;
      f = {1'b0, a, v};
      for (int i = 28; i >= 0; i--) tick(f[i], s);
      #500;
   endtask
   task automatic rd(input logic [11:0] a, output logic [15:0] v);
      logic [12:0] f;
      logic s;
      f = {1'b1, a};
      for (int i = 0; i < 37; i++) begin
         if (i < 13) tick(f[12-i], s);
         else tick(~d, s);
         if (i >= 20 && i < 36) v[35-i] = s;
      end
      #500;
   endtask
endmodule // pmt_prog_model
`default_nettype wire

// *** test/program_memory_table_read_bench.sv ***
// Self-checking bench for the program memory table read block
`timescale 1ns/1ps
`default_nettype none
module program_memory_table_read_bench;
   import pmt_pkg::*;
   logic clk, rst, prog_serial_clock, prog_enable, prog_serial_data_i, prog_serial_data_o, prog_serial_data_oe;
   logic jump_req, tblp_wr, tbhp_wr, tbl_rd_req, tbl_rd_last, alu_go, instr_valid_q, stall_q, dm_wr_q;
   logic port_a_bit0_fn_o, port_a_bit0_fn_oe, port_a_bit2_fn_o, port_a_bit2_fn_oe, skip_q, prog_busy_q;
   logic port_a_bit0_o, port_a_bit0_oe, port_a_bit2_o, port_a_bit2_oe;
   logic [11:0] jump_addr, pc_q;
   logic [15:0] instr_q, rv;
   logic [7:0] tbl_ptr_wdata, tbl_dest, alu_a, alu_b, alu_dest, dm_addr_q, dm_wdata_q, table_high_byte_latch_q;
   logic [3:0] status_q;
   pmt_alu_op_t alu_op;
   int fails = 0;
   int cmp_count = 0;
   pmt_table_core pmt_table_core_i (.clk, .rst, .prog_serial_clock, .prog_enable, .prog_serial_data_i,
      .prog_serial_data_o, .prog_serial_data_oe, .jump_req, .jump_addr, .tblp_wr, .tbhp_wr, .tbl_ptr_wdata,
      .tbl_rd_req, .tbl_rd_last, .tbl_dest, .alu_go, .alu_op, .alu_a, .alu_b, .alu_dest, .port_a_bit0_fn_o,
      .port_a_bit0_fn_oe, .port_a_bit2_fn_o, .port_a_bit2_fn_oe, .port_a_bit0_o, .port_a_bit0_oe,
      .port_a_bit2_o, .port_a_bit2_oe, .pc_q, .instr_q, .instr_valid_q, .stall_q, .dm_wr_q, .dm_addr_q,
      .dm_wdata_q, .table_high_byte_latch_q, .status_q, .skip_q, .prog_busy_q);
   pmt_prog_model pmt_prog_model_i (.ck(prog_serial_clock), .en(prog_enable), .pad(prog_serial_data_i),
      .dev_o(prog_serial_data_o), .dev_oe(prog_serial_data_oe));
   always #10 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic final_report;
      $display("fails=%0d cmp_count=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_load;
      chk({port_a_bit0_o, port_a_bit0_oe, port_a_bit2_o, port_a_bit2_oe}, 16'h000D);
      pmt_prog_model_i.mode(1'b0);
      pmt_prog_model_i.mode(1'b1);
      chk({port_a_bit0_o, port_a_bit0_oe, port_a_bit2_o, port_a_bit2_oe}, 16'h0000);
      chk(prog_busy_q, 1'b1);
      pmt_prog_model_i.wr(12'h000, 16'hA5C3);
      pmt_prog_model_i.wr(12'hF06, 16'h3C1A);
      pmt_prog_model_i.wr(12'hF05, 16'h0F96);
      pmt_prog_model_i.rd(12'hF06, rv);
      chk(rv, 16'h3C1A);
      pmt_prog_model_i.mode(1'b0);
      // Back onto the system clock grid before driving the core again
      cyc(1);
      chk({prog_busy_q, port_a_bit0_o, port_a_bit0_oe, port_a_bit2_o, port_a_bit2_oe}, 16'h000D);
   endtask
   task automatic t_fetch;
      rst = 1'b1;
      cyc(6);
      rst = 1'b0;
      chk(pc_q, PC_RESET_ADDR);
      for (int i = 0; i < 8 && instr_valid_q !== 1'b1; i++) cyc(1);
      chk(instr_q, 16'hA5C3);
      chk(instr_valid_q, 1'b1);
      jump_req = 1'b1;
      jump_addr = 12'hF06;
      cyc(1);
      jump_req = 1'b0;
      cyc(1);
      chk(instr_q, 16'h3C1A);
      chk(pc_q, 12'hF08);
   endtask
   task automatic ptr(input logic [7:0] lo, input logic [7:0] hi);
      tblp_wr = 1'b1;
      tbl_ptr_wdata = lo;
      cyc(1);
      {tblp_wr, tbhp_wr, tbl_ptr_wdata} = {2'b01, hi};
      cyc(1);
      tbhp_wr = 1'b0;
   endtask
   task automatic tbl(input logic last, input logic [7:0] dst, input logic [15:0] w);
      {tbl_rd_req, tbl_rd_last, tbl_dest} = {1'b1, last, dst};
      cyc(1);
      tbl_rd_req = 1'b0;
      chk(stall_q, 1'b1);
      cyc(1);
      chk({dm_wr_q, dm_addr_q}, {1'b1, dst});
      chk({dm_wdata_q, table_high_byte_latch_q}, {w[7:0], w[15:8]});
   endtask
   task automatic t_table;
      ptr(8'h06, 8'hFF);
      tbl(1'b0, 8'h20, 16'h3C1A);
      tbl(1'b1, 8'h21, 16'h3C1A);
      ptr(8'h05, 8'h00);
      tbl(1'b1, 8'h22, 16'h0F96);
   endtask
   task automatic alu(input pmt_alu_op_t op, input logic [7:0] a, input logic [7:0] b, input logic [7:0] d);
      alu_go = 1'b1;
      alu_op = op;
      alu_a = a;
      alu_b = b;
      alu_dest = d;
      cyc(1);
      alu_go = 1'b0;
   endtask
   task automatic t_alu;
      alu(ALU_ADD, 8'hFF, 8'h01, 8'h30);
      chk({dm_addr_q, dm_wdata_q}, 16'h3000);
      chk({dm_wr_q, skip_q, status_q}, 16'h0027);
      // No table read ran in between, so the latch still holds the last one
      chk(table_high_byte_latch_q, 16'h000F);
      cyc(1);
      alu(ALU_AND, 8'h3C, 8'h0F, 8'h31);
      chk({dm_addr_q, dm_wdata_q}, 16'h310C);
      chk({dm_wr_q, skip_q, status_q}, 16'h0023);
      cyc(1);
      alu(ALU_SZ, 8'h00, 8'h00, 8'h32);
      chk({dm_wr_q, skip_q, status_q}, 16'h0013);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {clk, rst, jump_req, jump_addr, tblp_wr, tbhp_wr, tbl_ptr_wdata} = '0;
      {tbl_rd_req, tbl_rd_last, tbl_dest, alu_go, alu_a, alu_b, alu_dest} = '0;
      alu_op = ALU_ADD;
      {port_a_bit0_fn_o, port_a_bit0_fn_oe, port_a_bit2_fn_o, port_a_bit2_fn_oe} = 4'hD;
      rst = 1'b1;
      cyc(6);
      rst = 1'b0;
      cyc(2);
      t_load;
      t_fetch;
      t_table;
      t_alu;
      final_report;
   end
   initial begin
      #100000;
      fails++;
      final_report;
   end
endmodule // program_memory_table_read_bench
`default_nettype wire

// *** verilog/pmt_flash_mem.sv ***
// Program memory array with a registered read port
`timescale 1ns/1ps
`default_nettype none
module pmt_flash_mem
   import pmt_pkg::*;
#(
   parameter int AW = PROG_AW,
   parameter int DW = PROG_DW
) (
   input wire logic clk,
   input wire logic rst,
   pmt_mem_if.mem port
);
   logic [DW-1:0] array_q [0:(1<<AW)-1];
   logic [DW-1:0] rdata_q;

   // Array itself has no reset; contents survive a device reset
   always_ff @(posedge clk) begin
      if (port.wr_en) begin
         array_q[port.addr] <= port.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (port.rd_en) begin
         rdata_q <= array_q[port.addr];
      end
   end

   assign port.rdata = rdata_q;
endmodule // pmt_flash_mem
`default_nettype wire

// *** verilog/pmt_mem_if.sv ***
// Port bundle between the sequencer and the program memory array
`timescale 1ns/1ps
`default_nettype none
interface pmt_mem_if #(parameter int AW = 12, parameter int DW = 16);
   logic rd_en;
   logic wr_en;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   modport ctrl (output rd_en, output wr_en, output addr, output wdata, input rdata);
   modport mem (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// *** verilog/pmt_pkg.sv ***
// Shared constants and types for the program memory table read block
`default_nettype none
package pmt_pkg;
   // Program memory shape
   localparam int PROG_AW = 12;
   localparam int PROG_DW = 16;
   localparam logic [11:0] PC_RESET_ADDR = 12'h000;
   localparam logic [3:0] TBL_LAST_PAGE = 4'hF;
   localparam logic [7:0] TBL_PTR_RESET = 8'h00;
   localparam logic [7:0] TABLE_HIGH_BYTE_LATCH_RESET = 8'h00;
   // Status register layout and reset value
   localparam logic [3:0] STATUS_RESET = 4'h0;
   localparam int ST_C = 0;
   localparam int ST_AC = 1;
   localparam int ST_Z = 2;
   localparam int ST_OV = 3;
   // Decimal adjust constants
   localparam logic [3:0] BCD_MAX = 4'h9;
   localparam logic [8:0] BCD_LO_ADJ = 9'h006;
   localparam logic [8:0] BCD_HI_ADJ = 9'h060;
   // Serial link frame: read flag, 12 address bits, then 16 data bits in or
   // 7 turnaround clocks and 16 data bits out
   localparam logic [5:0] LNK_ADDR_END = 6'h0C;
   localparam logic [5:0] LNK_WR_END = 6'h1C;
   localparam logic [5:0] LNK_RD_LOAD = 6'h14;
   localparam logic [5:0] LNK_RD_END = 6'h24;
   localparam logic [15:0] LNK_RD_NOT_READY = 16'hFFFF;
   localparam logic [2:0] SYNC_RESET = 3'h0;
   typedef enum logic [1:0] {SEQ_RUN, SEQ_TBL, SEQ_PROG} pmt_seq_t;
   typedef enum logic [4:0] {
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DECIMAL_ADJUST,
      ALU_AND, ALU_OR, ALU_XOR, ALU_CPL,
      ALU_RR, ALU_RRC, ALU_RL, ALU_RLC,
      ALU_INC, ALU_DEC,
      ALU_SZ, ALU_SNZ, ALU_SIZ, ALU_SDZ
   } pmt_alu_op_t;
endpackage
`default_nettype wire

// *** verilog/pmt_table_core.sv ***
// Program memory sequencer, table read path, ALU and serial programming port
`timescale 1ns/1ps
`default_nettype none
module pmt_table_core
   import pmt_pkg::*;
#(
   parameter int AW = PROG_AW,
   parameter int DW = PROG_DW
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic prog_serial_clock,
   input wire logic prog_enable,
   input wire logic prog_serial_data_i,
   output logic prog_serial_data_o,
   output logic prog_serial_data_oe,
   input wire logic jump_req,
   input wire logic [AW-1:0] jump_addr,
   input wire logic tblp_wr,
   input wire logic tbhp_wr,
   input wire logic [7:0] tbl_ptr_wdata,
   input wire logic tbl_rd_req,
   input wire logic tbl_rd_last,
   input wire logic [7:0] tbl_dest,
   input wire logic alu_go,
   input wire pmt_pkg::pmt_alu_op_t alu_op,
   input wire logic [7:0] alu_a,
   input wire logic [7:0] alu_b,
   input wire logic [7:0] alu_dest,
   input wire logic port_a_bit0_fn_o,
   input wire logic port_a_bit0_fn_oe,
   input wire logic port_a_bit2_fn_o,
   input wire logic port_a_bit2_fn_oe,
   output logic port_a_bit0_o,
   output logic port_a_bit0_oe,
   output logic port_a_bit2_o,
   output logic port_a_bit2_oe,
   output logic [AW-1:0] pc_q,
   output logic [DW-1:0] instr_q,
   output logic instr_valid_q,
   output logic stall_q,
   output logic dm_wr_q,
   output logic [7:0] dm_addr_q,
   output logic [7:0] dm_wdata_q,
   output logic [7:0] table_high_byte_latch_q,
   output logic [3:0] status_q,
   output logic skip_q,
   output logic prog_busy_q
);
   import pmt_pkg::*;

   localparam logic [7:0] TABLE_HIGH_BYTE_LATCH_MASK = 8'((1 << (DW - 8)) - 1);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   pmt_mem_if #(.AW(AW), .DW(DW)) mif ();
   pmt_seq_t seq_q;
   logic [2:0] en_sync_q;
   logic prog_mode_q;
   logic [2:0] req_sync_q;
   logic req_seen_q;
   logic ack_tgl_q;
   logic rd_pend_q;
   logic [DW-1:0] rd_hold_q;
   logic fetch_pend_q;
   logic [7:0] tblp_q;
   logic [7:0] tbhp_q;
   logic [7:0] tbl_dest_q;
   logic tbl_acc;
   logic alu_acc;
   logic req_new;
   logic [AW-1:0] tbl_addr;
   logic [AW-1:0] fetch_addr;
   // Link domain
   logic [2:0] lnk_en_sync_q;
   logic lnk_frame_q;
   logic [2:0] lnk_ack_sync_q;
   logic [5:0] lnk_cnt_q;
   logic lnk_rd_q;
   logic [27:0] lnk_sh_q;
   logic [AW-1:0] lnk_addr_q;
   logic [DW-1:0] lnk_wdata_q;
   logic lnk_req_tgl_q;
   logic [15:0] lnk_out_q;
   // ALU
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [7:0] add_b;
   logic add_cin;
   logic [8:0] daa9;
   logic [7:0] alu_res;
   logic [3:0] alu_flags;
   logic alu_wr;
   logic alu_skip;

   pmt_flash_mem #(.AW(AW), .DW(DW)) u_mem (
      .clk(clk),
      .rst(rst),
      .port(mif.mem)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sequencer and memory arbitration
   assign tbl_acc = (seq_q == SEQ_RUN) && !prog_mode_q && tbl_rd_req;
   assign alu_acc = (seq_q == SEQ_RUN) && !prog_mode_q && alu_go && !tbl_rd_req;
   assign req_new = (req_sync_q[1] == req_sync_q[2]) && (req_sync_q[2] != req_seen_q);
   // Upper pointer bits beyond the address range are dropped here
   assign tbl_addr = tbl_rd_last ? {TBL_LAST_PAGE, tblp_q} : {tbhp_q[AW-9:0], tblp_q};
   assign fetch_addr = jump_req ? jump_addr : pc_q;

   always_comb begin
      mif.rd_en = 1'b0;
      mif.wr_en = 1'b0;
      mif.addr = pc_q;
      mif.wdata = lnk_wdata_q;
      case (seq_q)
         SEQ_RUN: begin
            if (!prog_mode_q) begin
               mif.rd_en = 1'b1;
               mif.addr = tbl_rd_req ? tbl_addr : fetch_addr;
            end
         end
         SEQ_PROG: begin
            if (req_new) begin
               mif.addr = lnk_addr_q;
               mif.rd_en = lnk_rd_q;
               mif.wr_en = !lnk_rd_q;
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         seq_q <= SEQ_RUN;
         pc_q <= PC_RESET_ADDR;
         stall_q <= 1'b0;
      end else begin
         case (seq_q)
            SEQ_RUN: begin
               if (prog_mode_q) begin
                  seq_q <= SEQ_PROG;
                  stall_q <= 1'b1;
               end else if (tbl_rd_req) begin
                  seq_q <= SEQ_TBL;
                  stall_q <= 1'b1;
               end else begin
                  pc_q <= fetch_addr + AW'(1);
               end
            end
            SEQ_TBL: begin
               seq_q <= SEQ_RUN;
               stall_q <= 1'b0;
            end
            SEQ_PROG: begin
               if (!prog_mode_q) begin
                  seq_q <= SEQ_RUN;
                  pc_q <= PC_RESET_ADDR;
                  stall_q <= 1'b0;
               end
            end
            default: seq_q <= SEQ_RUN;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         fetch_pend_q <= 1'b0;
         instr_valid_q <= 1'b0;
         instr_q <= '0;
      end else begin
         fetch_pend_q <= (seq_q == SEQ_RUN) && !prog_mode_q && !tbl_rd_req;
         instr_valid_q <= fetch_pend_q;
         if (fetch_pend_q) begin
            instr_q <= mif.rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Table pointers, high byte latch and data register write port
   always_ff @(posedge clk) begin
      if (rst) begin
         tblp_q <= TBL_PTR_RESET;
         tbhp_q <= TBL_PTR_RESET;
         tbl_dest_q <= 8'h00;
         table_high_byte_latch_q <= TABLE_HIGH_BYTE_LATCH_RESET;
      end else begin
         if (tblp_wr) begin
            tblp_q <= tbl_ptr_wdata;
         end
         if (tbhp_wr) begin
            tbhp_q <= tbl_ptr_wdata;
         end
         if (tbl_acc) begin
            tbl_dest_q <= tbl_dest;
         end
         // No write path from software; only a completing table read loads it
         if (seq_q == SEQ_TBL) begin
            table_high_byte_latch_q <= mif.rdata[DW-1:8] & TABLE_HIGH_BYTE_LATCH_MASK;
         end
      end
   end

   // A table result and an ALU result never meet: the ALU is refused while a table read is taken
   always_ff @(posedge clk) begin
      if (rst) begin
         dm_wr_q <= 1'b0;
         dm_addr_q <= 8'h00;
         dm_wdata_q <= 8'h00;
      end else if (seq_q == SEQ_TBL) begin
         dm_wr_q <= 1'b1;
         dm_addr_q <= tbl_dest_q;
         dm_wdata_q <= mif.rdata[7:0];
      end else begin
         dm_wr_q <= alu_acc && alu_wr;
         if (alu_acc && alu_wr) begin
            dm_addr_q <= alu_dest;
            dm_wdata_q <= alu_res;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ALU
   always_comb begin
      add_b = alu_b;
      add_cin = 1'b0;
      case (alu_op)
         ALU_ADC: add_cin = status_q[ST_C];
         ALU_SUB: begin
            add_b = ~alu_b;
            add_cin = 1'b1;
         end
         ALU_SBC: begin
            add_b = ~alu_b;
            add_cin = status_q[ST_C];
         end
         default: add_cin = 1'b0;
      endcase
      sum9 = {1'b0, alu_a} + {1'b0, add_b} + {8'h00, add_cin};
      sum5 = {1'b0, alu_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
      daa9 = {1'b0, alu_a};
      if ((alu_a[3:0] > BCD_MAX) || status_q[ST_AC]) begin
         daa9 = daa9 + BCD_LO_ADJ;
      end
      if (daa9[8] || (daa9[7:4] > BCD_MAX) || status_q[ST_C]) begin
         daa9 = daa9 + BCD_HI_ADJ;
      end
   end

   always_comb begin
      alu_res = 8'h00;
      alu_flags = status_q;
      alu_wr = 1'b1;
      alu_skip = 1'b0;
      case (alu_op)
         ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
            alu_res = sum9[7:0];
            alu_flags[ST_C] = sum9[8];
            alu_flags[ST_AC] = sum5[4];
            alu_flags[ST_OV] = (alu_a[7] == add_b[7]) && (sum9[7] != alu_a[7]);
            alu_flags[ST_Z] = (sum9[7:0] == 8'h00);
         end
         ALU_DECIMAL_ADJUST: begin
            alu_res = daa9[7:0];
            alu_flags[ST_C] = daa9[8] || status_q[ST_C];
         end
         ALU_AND, ALU_OR, ALU_XOR, ALU_CPL: begin
            if (alu_op == ALU_AND) begin
               alu_res = alu_a & alu_b;
            end else if (alu_op == ALU_OR) begin
               alu_res = alu_a | alu_b;
            end else if (alu_op == ALU_XOR) begin
               alu_res = alu_a ^ alu_b;
            end else begin
               alu_res = ~alu_b;
            end
            alu_flags[ST_Z] = (alu_res == 8'h00);
         end
         ALU_RR: alu_res = {alu_b[0], alu_b[7:1]};
         ALU_RL: alu_res = {alu_b[6:0], alu_b[7]};
         ALU_RRC: begin
            alu_res = {status_q[ST_C], alu_b[7:1]};
            alu_flags[ST_C] = alu_b[0];
         end
         ALU_RLC: begin
            alu_res = {alu_b[6:0], status_q[ST_C]};
            alu_flags[ST_C] = alu_b[7];
         end
         ALU_INC, ALU_DEC: begin
            alu_res = (alu_op == ALU_INC) ? alu_b + 8'h01 : alu_b - 8'h01;
            alu_flags[ST_Z] = (alu_res == 8'h00);
         end
         ALU_SZ, ALU_SNZ: begin
            alu_wr = 1'b0;
            alu_skip = (alu_b == 8'h00) ^ (alu_op == ALU_SNZ);
         end
         ALU_SIZ, ALU_SDZ: begin
            // Skip tests leave the status flags untouched
            alu_res = (alu_op == ALU_SIZ) ? alu_b + 8'h01 : alu_b - 8'h01;
            alu_skip = (alu_res == 8'h00);
         end
         default: alu_wr = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         status_q <= STATUS_RESET;
         skip_q <= 1'b0;
      end else begin
         skip_q <= alu_acc && alu_skip;
         if (alu_acc) begin
            status_q <= alu_flags;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // System side of the programming link and shared port pins
   always_ff @(posedge clk) begin
      if (rst) begin
         en_sync_q <= SYNC_RESET;
         prog_mode_q <= 1'b0;
         req_sync_q <= SYNC_RESET;
         req_seen_q <= 1'b0;
         ack_tgl_q <= 1'b0;
         rd_pend_q <= 1'b0;
         rd_hold_q <= '0;
         prog_busy_q <= 1'b0;
      end else begin
         en_sync_q <= {en_sync_q[1:0], prog_enable};
         req_sync_q <= {req_sync_q[1:0], lnk_req_tgl_q};
         if (en_sync_q[1] == en_sync_q[2]) begin
            prog_mode_q <= en_sync_q[2];
         end
         prog_busy_q <= (seq_q == SEQ_PROG);
         rd_pend_q <= (seq_q == SEQ_PROG) && req_new && lnk_rd_q;
         if (seq_q != SEQ_PROG) begin
            // Between frames the ack toggle rests at zero and the seen flag follows the synchronised request toggle
            req_seen_q <= req_sync_q[2];
            ack_tgl_q <= 1'b0;
         end else if (req_new) begin
            req_seen_q <= req_sync_q[2];
            if (!lnk_rd_q) begin
               ack_tgl_q <= ~ack_tgl_q;
            end
         end else if (rd_pend_q) begin
            rd_hold_q <= mif.rdata;
            ack_tgl_q <= ~ack_tgl_q;
         end
      end
   end

   // Port functions lose the pins while the programmer owns them
   always_ff @(posedge clk) begin
      if (rst) begin
         port_a_bit0_o <= 1'b0;
         port_a_bit0_oe <= 1'b0;
         port_a_bit2_o <= 1'b0;
         port_a_bit2_oe <= 1'b0;
      end else begin
         port_a_bit0_o <= port_a_bit0_fn_o && !prog_mode_q;
         port_a_bit0_oe <= port_a_bit0_fn_oe && !prog_mode_q;
         port_a_bit2_o <= port_a_bit2_fn_o && !prog_mode_q;
         port_a_bit2_oe <= port_a_bit2_fn_oe && !prog_mode_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link domain: the programmer's clock; counter, read flag, request toggle and pin drive clear while the frame is down
   always_ff @(posedge prog_serial_clock) begin
      lnk_en_sync_q <= {lnk_en_sync_q[1:0], prog_enable};
      lnk_ack_sync_q <= {lnk_ack_sync_q[1:0], ack_tgl_q};
      if (lnk_en_sync_q[1] == lnk_en_sync_q[2]) begin
         lnk_frame_q <= lnk_en_sync_q[2];
      end
   end

   always_ff @(posedge prog_serial_clock) begin
      if (!lnk_frame_q) begin
         lnk_cnt_q <= 6'h00;
         lnk_rd_q <= 1'b0;
         lnk_req_tgl_q <= 1'b0;
         prog_serial_data_o <= 1'b0;
         prog_serial_data_oe <= 1'b0;
      end else begin
         lnk_sh_q <= {lnk_sh_q[26:0], prog_serial_data_i};
         lnk_cnt_q <= lnk_cnt_q + 6'h01;
         if (lnk_cnt_q == 6'h00) begin
            lnk_rd_q <= prog_serial_data_i;
         end
         if ((lnk_cnt_q == LNK_ADDR_END) && lnk_rd_q) begin
            lnk_addr_q <= {lnk_sh_q[AW-2:0], prog_serial_data_i};
            lnk_req_tgl_q <= ~lnk_req_tgl_q;
         end
         if ((lnk_cnt_q == LNK_WR_END) && !lnk_rd_q) begin
            lnk_addr_q <= lnk_sh_q[26:15];
            lnk_wdata_q <= {lnk_sh_q[DW-2:0], prog_serial_data_i};
            lnk_req_tgl_q <= ~lnk_req_tgl_q;
            lnk_cnt_q <= 6'h00;
         end
         if ((lnk_cnt_q == LNK_RD_LOAD) && lnk_rd_q) begin
            // An unanswered read shifts out all ones rather than stale data
            if (lnk_ack_sync_q[2] == lnk_req_tgl_q) begin
               prog_serial_data_o <= rd_hold_q[15];
               lnk_out_q <= {rd_hold_q[14:0], 1'b0};
            end else begin
               prog_serial_data_o <= LNK_RD_NOT_READY[15];
               lnk_out_q <= {LNK_RD_NOT_READY[14:0], 1'b0};
            end
            prog_serial_data_oe <= 1'b1;
         end else if (lnk_cnt_q == LNK_RD_END) begin
            prog_serial_data_oe <= 1'b0;
            lnk_cnt_q <= 6'h00;
         end else if (prog_serial_data_oe) begin
            prog_serial_data_o <= lnk_out_q[15];
            lnk_out_q <= {lnk_out_q[14:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   AST_PC_RESET: assert property ($fell(rst) |-> pc_q == PC_RESET_ADDR)
      else $error("pc not at reset vector after reset");
   AST_TBL_ADDR: assert property (tbl_acc |-> mif.rd_en && mif.addr == tbl_addr)
      else $error("table address not driven to memory");
   AST_TBL_HIGH_IGNORED: assert property (tbl_acc && !tbl_rd_last |->
      mif.addr[AW-1:8] == tbhp_q[AW-9:0])
      else $error("table high pointer bits misused");
   AST_TBL_WRITE: assert property (tbl_acc |=> ##1 (dm_wr_q && dm_addr_q == $past(tbl_dest, 2)
      && dm_wdata_q == $past(mif.rdata[7:0]) && table_high_byte_latch_q == $past(mif.rdata[15:8])))
      else $error("table read result misrouted");
   AST_TABLE_HIGH_BYTE_LATCH_UNUSED: assert property ((table_high_byte_latch_q & ~TABLE_HIGH_BYTE_LATCH_MASK) == 8'h00)
      else $error("unused latch bit set");
   AST_TBL_STALL: assert property (tbl_acc |=> stall_q && !mif.rd_en ##1 !stall_q)
      else $error("table read stall is not one cycle");
   AST_TABLE_HIGH_BYTE_LATCH_STABLE: assert property (seq_q != SEQ_TBL |=> $stable(table_high_byte_latch_q))
      else $error("latch changed without table read");
   AST_ALU_WRITE: assert property (alu_acc && alu_op == ALU_AND |=>
      dm_wr_q && dm_addr_q == $past(alu_dest) && dm_wdata_q == ($past(alu_a) & $past(alu_b))
      && status_q[ST_Z] == (dm_wdata_q == 8'h00))
      else $error("alu result or zero flag wrong");
   AST_ALU_CARRY: assert property (alu_acc && alu_op == ALU_ADD |=>
      {status_q[ST_C], dm_wdata_q} == {1'b0, $past(alu_a)} + {1'b0, $past(alu_b)})
      else $error("add result or carry wrong");
   AST_PORT_RELEASE: assert property (prog_mode_q |=> !port_a_bit0_oe && !port_a_bit2_oe)
      else $error("port function drives a programming pin");
   AST_LNK_DRIVE: assert property (@(posedge prog_serial_clock) disable iff (!lnk_frame_q)
      prog_serial_data_oe |-> lnk_rd_q && lnk_cnt_q > LNK_RD_LOAD)
      else $error("data pin driven outside read phase");

   COV_TBL_READ: cover property (tbl_acc ##2 dm_wr_q);
   COV_TBL_LAST: cover property (tbl_acc && tbl_rd_last);
   COV_PROG_WRITE: cover property (seq_q == SEQ_PROG && mif.wr_en);
   COV_PROG_READ: cover property (rd_pend_q ##1 ack_tgl_q);
endmodule // pmt_table_core
`default_nettype wire
